/* logic/cmcd_control.sv */
// Cell monitor control and diagnostics core with bus slave
`default_nettype none

// Overview of operation
// - Each frame is 24 bits, shifted in and out at once; input is not passed to output.
// - Input sampled on rising serial clock, output changed on falling.
// - First bit in is cell one balance; first out is cell one UV flag.
// - Status returns undervoltage, thermal shutdown and ready flags.
// - Aux select code with SC2 and SC3 set routes input via buffer.
// - Aux select code with SC2 clear, SC3 set routes input directly.
// - Two index bits pick one of three aux inputs, last makes high-Z.
// - Low-power bit disables the buffer and keeps the regulator on.
// - Thermal shutdown halts regulator, buffer and balancing outputs.
// - Serial link keeps working during thermal shutdown.
// - Each balance bit drives its cell switch; cleared bit means off.
// - On the 12-cell variant, bits for cells 13 to 16 are ignored.
// - Diagnostic bit during sampling enables sense input test leakage.
module cmcd_control #(
    parameter logic CELLS16_RST = 1'b1
) (
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic      [31:0]  hrdata,
    output logic              hreadyout,
    output logic              hresp,
    input  wire logic         sclk_link,
    input  wire logic         cs_n,
    input  wire logic         sdi,
    output logic              sdo,
    input  wire logic [15:0]  cell_undervoltage_flag,
    input  wire logic         thermal_alarm,
    input  wire logic         power_ready,
    input  wire logic         sampling_active,
    output logic      [15:0]  cell_balance_drive,
    output logic      [1:0]   aux_sel,
    output logic              analog_output_buffered,
    output logic              analog_output_direct,
    output logic              analog_output_hiz,
    output logic              buffer_amp_en,
    output logic              regulator_en,
    output logic              low_power_state,
    output logic              open_wire_leak_enable
);
    localparam int FB = cmcd_pkg::FRAME_BITS;
    localparam int NC = cmcd_pkg::CELLS;

    typedef struct packed {
        logic [1:0]          therm_sync;
        logic [1:0]          rdy_sync;
        logic [1:0]          samp_sync;
        logic [2:0]          tgl_sync;
        logic [FB-1:0]       word;
        logic                cells16;
        logic                ap_write;
        logic [31:0]         ap_addr;
        logic [31:0]         hrdata;
        logic                hreadyout;
        cmcd_pkg::cmcd_pwr_t pwr;
        logic [NC-1:0]       bal;
        logic [1:0]          sel;
        logic                buffered;
        logic                direct;
        logic                hiz;
        logic                amp;
        logic                regl;
        logic                lowp;
        logic                leak;
    } cmcd_core_t;

    cmcd_core_t r;
    cmcd_core_t next_r;

    cmcd_link_if lk ();

    // ========================================================
    // Link end on the serial clock
    cmcd_spi_link u_link (
        .sclk_link (sclk_link),
        .arst_n    (arst_n),
        .cs_n      (cs_n),
        .sdi       (sdi),
        .sdo       (sdo),
        .lk        (lk)
    );

    // Raw flags offered to the link, synchronised there
    // Each flag is a slow level, so a torn sample only shifts it a frame
    assign lk.status_raw = {{cmcd_pkg::STAT_PAD{1'b0}},
                            power_ready,
                            thermal_alarm,
                            cell_undervoltage_flag};

    // ========================================================
    // Helper functions
    function automatic logic hit(input logic [31:0] a,
                                 input logic [31:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [31:0] rd(input logic [31:0] a,
                                       input cmcd_core_t s);
        logic [31:0] v;
        v = '0;
        if (hit(a, cmcd_pkg::A_CTRL)) begin
            v[cmcd_pkg::C_CELLS16] = s.cells16;
        end else if (hit(a, cmcd_pkg::A_STAT)) begin
            v[NC-1:0]              = s.bal;
            v[cmcd_pkg::S_THERM]   = (s.pwr == cmcd_pkg::PW_HOT);
            v[cmcd_pkg::S_RDY]     = s.rdy_sync[1];
            v[cmcd_pkg::S_LOWP]    = s.lowp;
            v[cmcd_pkg::S_LEAK]    = s.leak;
        end else if (hit(a, cmcd_pkg::A_FRAME)) begin
            v[FB-1:0] = s.word;
        end
        rd = v;
    endfunction

    // ========================================================
    // Decoded fields of the applied control word
    logic       aux_route;
    logic [1:0] aux_idx;
    logic       ap_take;

    assign aux_route = !r.word[cmcd_pkg::B_CSE]
                       && r.word[cmcd_pkg::B_SC3];
    assign aux_idx   = {r.word[cmcd_pkg::B_SC1],
                        r.word[cmcd_pkg::B_SC0]};
    assign ap_take   = hsel && htrans[1] && hready;

    // ========================================================
    // Next state of the core
    always_comb begin
        next_r            = r;
        next_r.therm_sync = {r.therm_sync[0], thermal_alarm};
        next_r.rdy_sync   = {r.rdy_sync[0], power_ready};
        next_r.samp_sync  = {r.samp_sync[0], sampling_active};
        next_r.tgl_sync   = {r.tgl_sync[1:0], lk.tgl};
        next_r.hreadyout  = 1'b1;

        // New frame word taken once the toggle has crossed
        // The link holds the word for a whole frame, so it is stable here
        if (r.tgl_sync[2] != r.tgl_sync[1]) begin
            next_r.word = lk.word;
        end

        // Write data phase
        if (r.ap_write && hit(r.ap_addr, cmcd_pkg::A_CTRL)) begin
            next_r.cells16 = hwdata[cmcd_pkg::C_CELLS16];
        end

        // Address phase; read data prepared for the data phase
        next_r.ap_write = 1'b0;
        if (ap_take) begin
            next_r.ap_write = hwrite;
            next_r.ap_addr  = haddr;
            if (!hwrite) begin
                next_r.hrdata = rd(haddr, next_r);
            end
        end

        // Power state
        case (r.pwr)
            cmcd_pkg::PW_RUN: begin
                if (r.therm_sync[1]) begin
                    next_r.pwr = cmcd_pkg::PW_HOT;
                end else if (r.word[cmcd_pkg::B_LOW_POWER_SHUTDOWN_BIT]) begin
                    next_r.pwr = cmcd_pkg::PW_LOW;
                end
            end
            cmcd_pkg::PW_LOW: begin
                if (r.therm_sync[1]) begin
                    next_r.pwr = cmcd_pkg::PW_HOT;
                end else if (!r.word[cmcd_pkg::B_LOW_POWER_SHUTDOWN_BIT]) begin
                    next_r.pwr = cmcd_pkg::PW_RUN;
                end
            end
            cmcd_pkg::PW_HOT: begin
                if (!r.therm_sync[1]) begin
                    next_r.pwr = r.word[cmcd_pkg::B_LOW_POWER_SHUTDOWN_BIT]
                                 ? cmcd_pkg::PW_LOW
                                 : cmcd_pkg::PW_RUN;
                end
            end
            default: begin
                next_r.pwr = cmcd_pkg::PW_RUN;
            end
        endcase

        // Balance drive, masked for the small variant and when hot
        next_r.bal = r.word[NC-1:0];
        if (!r.cells16) begin
            next_r.bal = next_r.bal & cmcd_pkg::BAL_MASK12;
        end
        if (r.pwr == cmcd_pkg::PW_HOT) begin
            next_r.bal = '0;
        end

        // Enables
        next_r.amp  = (r.pwr == cmcd_pkg::PW_RUN);
        next_r.regl = (r.pwr != cmcd_pkg::PW_HOT);
        next_r.lowp = (r.pwr == cmcd_pkg::PW_LOW);
        next_r.leak = r.word[cmcd_pkg::B_OPEN_WIRE_LEAK_ENABLE]
                      && r.samp_sync[1];

        // Auxiliary routing to the analog output
        next_r.sel      = aux_idx;
        next_r.hiz      = aux_route && aux_idx == cmcd_pkg::AUX_HIZ;
        next_r.buffered = aux_route && !next_r.hiz
                          && r.word[cmcd_pkg::B_SC2]
                          && r.pwr == cmcd_pkg::PW_RUN;
        next_r.direct   = aux_route && !next_r.hiz
                          && !r.word[cmcd_pkg::B_SC2];
    end

    // State register
    // Bus ready stays low until the first edge after reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r         <= '0;
            r.cells16 <= CELLS16_RST;
            r.pwr     <= cmcd_pkg::PW_RUN;
        end else begin
            r <= next_r;
        end
    end

    // ========================================================
    // Outputs
    assign hrdata                = r.hrdata;
    assign hreadyout             = r.hreadyout;
    assign hresp                 = 1'b0;
    assign cell_balance_drive    = r.bal;
    assign aux_sel               = r.sel;
    assign analog_output_buffered         = r.buffered;
    assign analog_output_direct           = r.direct;
    assign analog_output_hiz              = r.hiz;
    assign buffer_amp_en         = r.amp;
    assign regulator_en          = r.regl;
    assign low_power_state       = r.lowp;
    assign open_wire_leak_enable = r.leak;

    // ========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_new_frame;
        r.tgl_sync[2] != r.tgl_sync[1];
    endsequence

    sequence s_read_frame;
        ap_take && !hwrite && haddr == cmcd_pkg::A_FRAME;
    endsequence

    sequence s_write_ctrl;
        ap_take && hwrite && haddr == cmcd_pkg::A_CTRL;
    endsequence

    sequence s_read_stat;
        ap_take && !hwrite && haddr == cmcd_pkg::A_STAT;
    endsequence

    a_word_capture: assert property (
        s_new_frame |=> r.word == $past(lk.word))
        else $error("crossed frame word not captured");
    a_thermal_halt: assert property (
        r.therm_sync[1] |-> ##2 (!regulator_en && !buffer_amp_en
                                 && cell_balance_drive == '0))
        else $error("outputs not halted in thermal shutdown");
    a_low_power: assert property (
        r.pwr == cmcd_pkg::PW_LOW
        |=> !buffer_amp_en && regulator_en && low_power_state)
        else $error("low power enables wrong");
    a_cell_mask: assert property (
        !r.cells16 |=> cell_balance_drive[NC-1:12] == '0)
        else $error("upper cells driven on small variant");
    a_bal_follow: assert property (
        r.pwr != cmcd_pkg::PW_HOT && r.cells16
        |=> cell_balance_drive == $past(r.word[NC-1:0]))
        else $error("balance drive does not follow word");
    a_aux_buffered: assert property (
        aux_route && r.word[cmcd_pkg::B_SC2]
        && aux_idx != cmcd_pkg::AUX_HIZ && r.pwr == cmcd_pkg::PW_RUN
        |=> analog_output_buffered && !analog_output_direct && aux_sel == $past(aux_idx))
        else $error("buffered aux route wrong");
    a_aux_direct: assert property (
        aux_route && !r.word[cmcd_pkg::B_SC2]
        && aux_idx != cmcd_pkg::AUX_HIZ
        |=> analog_output_direct && !analog_output_buffered && !analog_output_hiz)
        else $error("direct aux route wrong");
    a_aux_hiz: assert property (
        aux_route && aux_idx == cmcd_pkg::AUX_HIZ
        |=> analog_output_hiz && !analog_output_direct && !analog_output_buffered)
        else $error("aux high impedance code wrong");
    a_leak_open_wire_leak_enable: assert property (
        r.word[cmcd_pkg::B_OPEN_WIRE_LEAK_ENABLE] && r.samp_sync[1]
        |=> open_wire_leak_enable)
        else $error("test leakage not enabled");
    a_read_frame: assert property (
        s_read_frame |=> hreadyout && hrdata[FB-1:0] == $past(next_r.word))
        else $error("frame register read wrong");
    a_ctrl_write: assert property (
        s_write_ctrl ##1 hreadyout |=> r.cells16
                                     == $past(hwdata[cmcd_pkg::C_CELLS16]))
        else $error("control register not written");
    a_buffer_gated: assert property (
        r.pwr != cmcd_pkg::PW_RUN |=> !analog_output_buffered)
        else $error("buffered route live outside run state");
    a_no_route: assert property (
        !aux_route |=> !analog_output_buffered && !analog_output_direct && !analog_output_hiz)
        else $error("analog output routed without aux code");
    a_leak_gate: assert property (
        !r.word[cmcd_pkg::B_OPEN_WIRE_LEAK_ENABLE] || !r.samp_sync[1]
        |=> !open_wire_leak_enable)
        else $error("test leakage on outside sampling");
    a_hot_enter: assert property (
        r.therm_sync[1] && r.pwr != cmcd_pkg::PW_HOT
        |=> r.pwr == cmcd_pkg::PW_HOT)
        else $error("thermal shutdown not entered");
    a_hot_exit: assert property (
        r.pwr == cmcd_pkg::PW_HOT && !r.therm_sync[1]
        |=> r.pwr != cmcd_pkg::PW_HOT)
        else $error("thermal shutdown not left");
    a_bal_hot: assert property (
        r.pwr == cmcd_pkg::PW_HOT |=> cell_balance_drive == '0)
        else $error("balancing left on in thermal shutdown");
    a_status_read: assert property (
        s_read_stat |=> hrdata[cmcd_pkg::S_RDY] == $past(r.rdy_sync[1])
        && hrdata[cmcd_pkg::S_THERM] == ($past(r.pwr) == cmcd_pkg::PW_HOT))
        else $error("status register flags wrong");
endmodule

`default_nettype wire

/* logic/cmcd_pkg.sv */
// Shared constants and types of the cell monitor control block
`default_nettype none

package cmcd_pkg;
    // ========================================================
    // Serial frame layout (first bit received lands in bit 0)
    localparam int FRAME_BITS = 24;
    localparam int CELLS      = 16;
    localparam int CNT_W      = 5;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h17;
    localparam int B_CSE  = 16;  // cell_select_enable
    localparam int B_SC0  = 17;  // select_code_bit0 (index b)
    localparam int B_SC1  = 18;  // select_code_bit1 (index a)
    localparam int B_SC2  = 19;  // select_code_bit2
    localparam int B_SC3  = 20;  // select_code_bit3
    localparam int B_OPEN_WIRE_LEAK_ENABLE = 22;  // open_wire_leak_enable
    localparam int B_LOW_POWER_SHUTDOWN_BIT = 23;  // low_power_shutdown_bit
    // Returned status layout (first bit sent is bit 0)
    localparam int S_THERM = 16;
    localparam int S_RDY   = 17;
    localparam int S_LOWP  = 18;
    localparam int S_LEAK  = 19;
    localparam int STAT_PAD = 6;
    // ========================================================
    // Auxiliary routing
    localparam logic [1:0] AUX_HIZ = 2'h3;
    localparam logic [CELLS-1:0] BAL_MASK12 = 16'h0FFF;
    // ========================================================
    // Register map
    localparam logic [31:0] A_CTRL  = 32'h0000_0000;
    localparam logic [31:0] A_STAT  = 32'h0000_0004;
    localparam logic [31:0] A_FRAME = 32'h0000_0008;
    localparam int C_CELLS16 = 0;
    // ========================================================
    // Power state
    typedef enum logic [2:0] {
        PW_RUN = 3'h1,
        PW_LOW = 3'h2,
        PW_HOT = 3'h4
    } cmcd_pwr_t;
endpackage

`default_nettype wire

/* logic/cmcd_link_if.sv */
// Signals passed between the link end and the core
`default_nettype none

interface cmcd_link_if;
    logic [cmcd_pkg::FRAME_BITS-1:0] status_raw;
    logic [cmcd_pkg::FRAME_BITS-1:0] word;
    logic                            tgl;
    modport link (input status_raw, output word, output tgl);
    modport core (output status_raw, input word, input tgl);
endinterface

`default_nettype wire

/* logic/cmcd_spi_link.sv */
// Serial shift logic on the link clock
`default_nettype none

module cmcd_spi_link (
    input  wire logic  sclk_link,
    input  wire logic  arst_n,
    input  wire logic  cs_n,
    input  wire logic  sdi,
    output var  logic  sdo,
    cmcd_link_if.link  lk
);
    typedef struct packed {
        logic [cmcd_pkg::FRAME_BITS-1:0] s1;
        logic [cmcd_pkg::FRAME_BITS-1:0] s2;
        logic [cmcd_pkg::FRAME_BITS-1:0] rx;
        logic [cmcd_pkg::FRAME_BITS-1:0] tx;
        logic [cmcd_pkg::CNT_W-1:0]      cnt;
        logic [cmcd_pkg::FRAME_BITS-1:0] word;
        logic                            tgl;
    } cmcd_lnk_t;

    cmcd_lnk_t r;
    cmcd_lnk_t next_r;
    logic [cmcd_pkg::FRAME_BITS-1:0] rx_in;

    // ========================================================
    // Frame shifting
    assign rx_in = {sdi, r.rx[cmcd_pkg::FRAME_BITS-1:1]};

    // Sample on rising edges; latch word and reload status at bit 24
    always_comb begin
        next_r    = r;
        next_r.s1 = lk.status_raw;
        next_r.s2 = r.s1;
        if (cs_n) begin
            next_r.cnt = '0;
        end else begin
            next_r.rx = rx_in;
            next_r.tx = {1'b0, r.tx[cmcd_pkg::FRAME_BITS-1:1]};
            if (r.cnt == cmcd_pkg::CNT_LAST) begin
                next_r.cnt  = '0;
                next_r.word = rx_in;
                next_r.tgl  = ~r.tgl;
                next_r.tx   = r.s2;
            end else begin
                next_r.cnt = r.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge sclk_link or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Outgoing bit changes on falling edges
    always_ff @(negedge sclk_link or negedge arst_n) begin
        if (!arst_n) begin
            sdo <= 1'b0;
        end else begin
            sdo <= r.tx[0];
        end
    end

    assign lk.word = r.word;
    assign lk.tgl  = r.tgl;

    // ========================================================
    // Checks
    sequence s_last_bit;
        !cs_n && r.cnt == cmcd_pkg::CNT_LAST;
    endsequence

    a_frame_latch: assert property (
        @(posedge sclk_link) disable iff (!arst_n)
        s_last_bit |=> lk.tgl != $past(lk.tgl)
                       && lk.word == $past(rx_in))
        else $error("frame word not latched at bit 24");
    a_status_load: assert property (
        @(posedge sclk_link) disable iff (!arst_n)
        s_last_bit |=> r.tx == $past(r.s2))
        else $error("status not loaded for next frame");
    a_count_idle: assert property (
        @(posedge sclk_link) disable iff (!arst_n)
        cs_n |=> r.cnt == '0)
        else $error("bit count not cleared while deselected");
endmodule

`default_nettype wire

/* tb/cmcd_host_model.sv */
// Host-side serial model that frames whole 24-bit control words
`default_nettype none

module cmcd_host_model (
    output var  logic sclk_link,
    output var  logic cs_n,
    output var  logic sdi,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================
    // Serial framing
    localparam time HALF = 40ns;

    // Idle: clock stands low, device deselected
    initial begin
        sclk_link = 1'b0;
        cs_n      = 1'b1;
        sdi       = 1'b0;
    end

    // One frame: drive on falling edges, sample on rising edges
    task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
        rx   = 24'h000000;
        #3ns;  // Keeps link edges off the system clock edges
        cs_n = 1'b0;
        for (int k = 0; k < 24; k++) begin
            sdi = tx[k];
            #HALF;
            sclk_link = 1'b1;
            rx[k]     = sdo;
            #HALF;
            sclk_link = 1'b0;
        end
        #HALF;
        cs_n = 1'b1;
        sdi  = ~sdi;                                    // Data line inverted after deselect
        #HALF;
    endtask
endmodule

`default_nettype wire

/* tb/cmcd_control_bench.sv */
// Self-checking bench for the cell monitor control block
`default_nettype none

`define CHK(nm, ex, got) begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
        n_errors++; \
        $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
end

module cmcd_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================
    // Signals
    logic        clk_sys;
    logic        arst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire logic   hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        sclk_link;
    logic        cs_n;
    logic        sdi;
    logic        sdo;
    logic [15:0] uv;
    logic        thermal_alarm;
    logic        power_ready;
    logic        sampling_active;
    logic [15:0] bal;
    logic [1:0]  aux_sel;
    logic        analog_output_buffered;
    logic        analog_output_direct;
    logic        analog_output_hiz;
    logic        buffer_amp_en;
    logic        regulator_en;
    logic        low_power_state;
    logic        leak;
    int          n_errors;
    int          num_checks;
    logic [31:0] r;
    logic [23:0] rx;
    logic [23:0] w;

    // Single slave: its ready is the bus ready
    assign hready = hreadyout;

    // System clock
    initial clk_sys = 1'b0;
    always #5ns clk_sys = ~clk_sys;

    // ========================================================
    // Instances
    cmcd_control cmcd_control_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sclk_link(sclk_link), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .cell_undervoltage_flag(uv),
        .thermal_alarm(thermal_alarm), .power_ready(power_ready),
        .sampling_active(sampling_active), .cell_balance_drive(bal),
        .aux_sel(aux_sel), .analog_output_buffered(analog_output_buffered),
        .analog_output_direct(analog_output_direct), .analog_output_hiz(analog_output_hiz),
        .buffer_amp_en(buffer_amp_en), .regulator_en(regulator_en),
        .low_power_state(low_power_state),
        .open_wire_leak_enable(leak)
    );

    cmcd_host_model host_inst (
        .sclk_link(sclk_link), .cs_n(cs_n), .sdi(sdi), .sdo(sdo)
    );

    // ========================================================
    // Verdict and bus tasks
    task automatic give_verdict();
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Bounded wait for ready sampled high at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                n_errors++;
                give_verdict();
            end
            @(posedge clk_sys);
        end
    endtask

    // Address phase, then data phase with write data
    task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask

    // Address phase, then read data taken at the closing edge
    task automatic ahb_rd(input logic [31:0] a, output logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        wait_rdy();
        d = hrdata;
    endtask

    // Send a frame, then poll the applied word until it has crossed
    task automatic frame(input logic [23:0] fw, output logic [23:0] frx);
        logic [31:0] fr;
        host_inst.xfer(fw, frx);
        @(posedge clk_sys);
        for (int i = 0; i < 20; i++) begin
            ahb_rd(cmcd_pkg::A_FRAME, fr);
            if (fr[23:0] === fw)
                break;
        end
        `CHK("frame word", {8'h00, fw}, fr)
        repeat (2) @(posedge clk_sys);
    endtask

    // Bounded wait for the regulator enable to reach a level
    task automatic wait_reg(input logic v);
        int n;
        n = 0;
        while (regulator_en !== v && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK("regulator_en", v, regulator_en)
        if (regulator_en !== v)
            give_verdict();
    endtask

    // ========================================================
    // Main sequence
    initial begin
        n_errors = 0;
        num_checks = 0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        uv = 16'h0000;
        thermal_alarm = 1'b0;
        power_ready = 1'b1;
        sampling_active = 1'b0;
        arst_n = 1'b0;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        // Reset values, read-back and unmapped space
        ahb_rd(cmcd_pkg::A_CTRL, r);
        `CHK("ctrl reset", 32'h0000_0001, r)
        `CHK("regulator reset", 1'b1, regulator_en)
        `CHK("buffer reset", 1'b1, buffer_amp_en)
        ahb_wr(32'h0000_0010, 32'hFFFF_FFFF);
        ahb_rd(32'h0000_0010, r);
        `CHK("unmapped", 32'h0000_0000, r)
        ahb_wr(cmcd_pkg::A_CTRL, 32'h0000_0000);
        ahb_rd(cmcd_pkg::A_CTRL, r);
        `CHK("ctrl write", 32'h0000_0000, r)
        // Twelve-cell variant ignores the upper balance bits
        frame(24'h01FFFF, rx);
        `CHK("first status", 24'h000000, rx)
        `CHK("bal 12 cells", 16'h0FFF, bal)
        ahb_wr(cmcd_pkg::A_CTRL, 32'h0000_0001);
        frame(24'h01A5C3, rx);
        `CHK("bal pattern", 16'hA5C3, bal)
        ahb_wr(cmcd_pkg::A_STAT, 32'hFFFF_FFFF);
        ahb_rd(cmcd_pkg::A_STAT, r);
        `CHK("status bal", 16'hA5C3, r[15:0])
        `CHK("okay resp", 1'b0, hresp)
        // Single-cell balance as used for switch open-wire testing
        frame(24'h010004, rx);
        `CHK("bal one cell", 16'h0004, bal)
        // Every aux index, buffered and direct
        for (int i = 0; i < 4; i++) begin
            for (int s = 0; s < 2; s++) begin
                w = 24'h000000;
                w[cmcd_pkg::B_SC3] = 1'b1;
                w[cmcd_pkg::B_SC2] = s[0];
                w[cmcd_pkg::B_SC1] = i[1];
                w[cmcd_pkg::B_SC0] = i[0];
                frame(w, rx);
                `CHK("aux_sel", i[1:0], aux_sel)
                `CHK("analog_output_hiz", (i == 3), analog_output_hiz)
                if (i != 3) begin
                    `CHK("buffered", s[0], analog_output_buffered)
                    `CHK("direct", ~s[0], analog_output_direct)
                end
            end
        end
        // Low-power shutdown, then back to run
        frame(24'h980000, rx);
        `CHK("lp buffer", 1'b0, buffer_amp_en)
        `CHK("lp regulator", 1'b1, regulator_en)
        `CHK("lp state", 1'b1, low_power_state)
        `CHK("lp buffered", 1'b0, analog_output_buffered)
        frame(24'h180000, rx);
        `CHK("run buffer", 1'b1, buffer_amp_en)
        `CHK("run buffered", 1'b1, analog_output_buffered)
        // Leakage test: set the diagnostic bit while sampling
        sampling_active <= 1'b1;
        frame(24'h410000, rx);
        `CHK("leak on", 1'b1, leak)
        ahb_rd(cmcd_pkg::A_STAT, r);
        `CHK("leak flag", 1'b1, r[cmcd_pkg::S_LEAK])
        sampling_active <= 1'b0;
        repeat (4) @(posedge clk_sys);
        `CHK("leak hold", 1'b0, leak)
        // Status flags load for the following frame
        uv <= 16'h1234;
        frame(24'h010001, rx);
        frame(24'h010002, rx);
        `CHK("status word", 24'h021234, rx)
        power_ready <= 1'b0;
        repeat (3) @(posedge clk_sys);
        ahb_rd(cmcd_pkg::A_STAT, r);
        `CHK("status ready", 1'b0, r[cmcd_pkg::S_RDY])
        power_ready <= 1'b1;
        // Thermal shutdown halts outputs, link stays alive
        frame(24'h0100FF, rx);
        thermal_alarm <= 1'b1;
        wait_reg(1'b0);
        `CHK("hot buffer", 1'b0, buffer_amp_en)
        `CHK("hot balance", 16'h0000, bal)
        ahb_rd(cmcd_pkg::A_STAT, r);
        `CHK("status hot", 1'b1, r[16])
        frame(24'h01000F, rx);
        frame(24'h01000E, rx);
        `CHK("returned hot", 1'b1, rx[cmcd_pkg::S_THERM])
        thermal_alarm <= 1'b0;
        wait_reg(1'b1);
        repeat (3) @(posedge clk_sys);
        `CHK("bal restored", 16'h000E, bal)
        give_verdict();
    end
endmodule

`default_nettype wire
